// ===== design/ocd_top.sv
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "ocd_defines.svh"

module ocd_top
    import ocd_pkg::*;
(
    input  wire logic             CLK,
    input  wire logic             RST,
    input  wire logic             CYC_I,
    input  wire logic             STB_I,
    input  wire logic             WE_I,
    input  wire logic [7:0]       ADR_I,
    input  wire logic [3:0]       SEL_I,
    input  wire logic [31:0]      DAT_I,
    output logic                  ACK_O,
    output logic      [31:0]      DAT_O,
    input  wire logic [1:0]       CFG_SWITCHING,
    input  wire ocd_pkg::ocd_src_t CFG_POWERON_SRC,
    input  wire logic             CFG_PRI_CRYSTAL,
    input  wire logic             CFG_SEC_CRYSTAL,
    input  wire logic             CFG_SEC_HIGHPWR,
    input  wire logic             LOW_POWER_RC_USERS,
    input  wire logic             IRQ,
    input  wire logic             FAIL_DETECT,
    input  wire logic             STARTUP_DONE,
    input  wire logic             PLL_LOCKED,
    input  wire logic             NEW_CLK,
    output ocd_pkg::ocd_src_t     SYS_SOURCE,
    output logic                  PRI_ON,
    output logic                  SEC_ON,
    output logic                  SEC_HIGH_DRIVE,
    output logic                  FRC_ON,
    output logic                  SLOW_FRC_ON,
    output logic                  LOW_POWER_RC_ON,
    output logic                  PLL_ON,
    output logic      [2:0]       DOZE_SHIFT,
    output logic      [3:0]       RC_DIV_SHIFT,
    output logic      [5:0]       RC_TRIM
);
    import ocd_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [1:0]  cfg_sw_q, cfg_sw_d;          // Switching config bits
    ocd_src_t    cfg_src_q, cfg_src_d;        // Power-on source
    ocd_src_t    current_source_q, current_source_d;              // Current source
    ocd_src_t    new_source_select_q, new_source_select_d;              // New source select
    logic        switch_request_q, switch_request_d;            // Switch request
    logic        selection_lock_q, selection_lock_d;        // Selection lock
    logic        lock_q, lock_d;              // PLL lock status
    logic        cf_q, cf_d;                  // Clock fail flag
    logic        drv_q, drv_d;                // Secondary drive select
    logic        secen_q, secen_d;            // Secondary enable
    ocd_state_t  state_q, state_d;            // Switch sequencer
    logic [3:0]  tick_q, tick_d;              // New clock edge count
    logic        nclk_q;                      // Delayed sync new clock
    logic        roi_q, roi_d;                // Recover on interrupt
    logic [2:0]  doze_q, doze_d;              // Ratio code
    logic        ratio_enable_q, ratio_enable_d;            // Ratio enable
    logic [2:0]  rc_postscaler_q, rc_postscaler_d;            // RC postscaler code
    logic [5:0]  trim_q, trim_d;              // RC trim
    logic        ack_d;
    logic [31:0] dat_d;
    logic [3:0]  async_s;                     // Synced fail, timer, pll, clock
    logic        fail_s, ost_s, pll_s, nclk_s;
    logic        wr, rd, hit_osc, hit_div, hit_trim;
    logic        hi_open, lo_open;
    logic        sw_en, failsafe_monitor_en, frozen;
    logic        tick, start_valid;
    logic [5:0]  pwr_d;

    // ----------------------------------------
    // Source helpers
    // ----------------------------------------
    // True for codes that run through the PLL
    function automatic logic uses_pll(input ocd_src_t s);
        uses_pll = (s == `OCD_SRC_FAST_RC_MULTIPLIED) || (s == `OCD_SRC_PRIPLL);
    endfunction

    // True when the source is a crystal needing the start-up timer
    function automatic logic needs_ost(input ocd_src_t s, input logic pri_x,
                                       input logic sec_x);
        needs_ost = ((s == `OCD_SRC_PRI || s == `OCD_SRC_PRIPLL) && pri_x)
                  || (s == `OCD_SRC_SEC && sec_x);
    endfunction

    // Oscillators a source needs: {pri, sec, frc, slow, low_power_rc, pll}
    function automatic logic [5:0] src_use(input ocd_src_t s);
        case (s)
            `OCD_SRC_FRC:     src_use = 6'h08;
            `OCD_SRC_FAST_RC_MULTIPLIED:  src_use = 6'h09;
            `OCD_SRC_PRI:     src_use = 6'h20;
            `OCD_SRC_PRIPLL:  src_use = 6'h21;
            `OCD_SRC_SEC:     src_use = 6'h10;
            `OCD_SRC_LOW_POWER_RC:    src_use = 6'h02;
            `OCD_SRC_SLOWDIV: src_use = 6'h04;
            default:          src_use = 6'h08;
        endcase
    endfunction

    // ----------------------------------------
    // Synchronisers and unlock trackers
    // ----------------------------------------
    ocd_sync #(.W(4)) u_sync (
        .clk (CLK),
        .rst (RST),
        .d   ({FAIL_DETECT, STARTUP_DONE, PLL_LOCKED, NEW_CLK}),
        .q   (async_s)
    );
    assign {fail_s, ost_s, pll_s, nclk_s} = async_s;

    // Key writes land on the byte itself but never store
    ocd_unlock #(.KEY1(`OCD_KEY_HI1), .KEY2(`OCD_KEY_HI2)) u_unl_hi (
        .clk  (CLK),
        .rst  (RST),
        .acc  (wr),
        .hit  (hit_osc && SEL_I[1]),
        .data (DAT_I[15:8]),
        .open (hi_open)
    );
    ocd_unlock #(.KEY1(`OCD_KEY_LO1), .KEY2(`OCD_KEY_LO2)) u_unl_lo (
        .clk  (CLK),
        .rst  (RST),
        .acc  (wr),
        .hit  (hit_osc && SEL_I[0]),
        .data (DAT_I[7:0]),
        .open (lo_open)
    );

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    assign wr       = CYC_I && STB_I && WE_I && !ACK_O;
    assign rd       = CYC_I && STB_I && !WE_I && !ACK_O;
    assign hit_osc  = (ADR_I == `OCD_OFS_OSC);
    assign hit_div  = (ADR_I == `OCD_OFS_DIV);
    assign hit_trim = (ADR_I == `OCD_OFS_TRIM);
    assign sw_en    = !cfg_sw_q[1];
    assign failsafe_monitor_en  = (cfg_sw_q == 2'b00);
    assign frozen   = failsafe_monitor_en && selection_lock_q;
    assign tick     = nclk_s && !nclk_q;
    assign start_valid = (state_q == ST_CMP) && (new_source_select_q != current_source_q);

    // ----------------------------------------
    // Oscillator control and switch sequencer
    // ----------------------------------------
    always_comb
    begin
        cfg_sw_d  = cfg_sw_q;
        cfg_src_d = cfg_src_q;
        current_source_d    = current_source_q;
        new_source_select_d    = new_source_select_q;
        switch_request_d   = switch_request_q;
        selection_lock_d = selection_lock_q;
        lock_d    = 1'b0;
        cf_d      = cf_q;
        drv_d     = drv_q;
        secen_d   = secen_q;
        state_d   = state_q;
        tick_d    = tick_q;
        if (RST)
        begin
            // Straps caught while reset is held
            cfg_sw_d  = CFG_SWITCHING;
            cfg_src_d = CFG_POWERON_SRC;
            current_source_d    = CFG_POWERON_SRC;
            new_source_select_d    = CFG_POWERON_SRC;
            switch_request_d   = 1'b0;
            selection_lock_d = 1'b0;
            cf_d      = 1'b0;
            drv_d     = 1'b0;
            secen_d   = 1'b0;
            state_d   = ST_IDLE;
            tick_d    = 4'h0;
        end
        else
        begin
            // Upper byte: new source select
            if (wr && hit_osc && SEL_I[1] && hi_open && !frozen)
                new_source_select_d = DAT_I[`OCD_NEW_SOURCE_SELECT_LSB +: 3];
            // Lower byte: control bits
            if (wr && hit_osc && SEL_I[0] && lo_open)
            begin
                if (DAT_I[`OCD_B_SELECTION_LOCK])
                    selection_lock_d = 1'b1;          // Settable only
                if (!DAT_I[`OCD_B_FAIL])
                    cf_d = 1'b0;               // Clearable only
                drv_d   = DAT_I[`OCD_B_SECDRV];
                secen_d = DAT_I[`OCD_B_SECEN];
                if (DAT_I[`OCD_B_SWREQ] && !frozen && state_q == ST_IDLE)
                    switch_request_d = 1'b1;
            end
            // Sequencer
            case (state_q)
                ST_IDLE:
                begin
                    if (switch_request_q)
                        state_d = ST_CMP;
                end
                ST_CMP:
                begin
                    if (new_source_select_q == current_source_q)
                    begin
                        switch_request_d = 1'b0;
                        state_d = ST_IDLE;
                    end
                    else
                    begin
                        cf_d    = 1'b0;
                        state_d = ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    // New source is powered; wait timer and lock
                    if ((!needs_ost(new_source_select_q, CFG_PRI_CRYSTAL, CFG_SEC_CRYSTAL)
                         || ost_s) && (!uses_pll(new_source_select_q) || pll_s))
                    begin
                        tick_d  = 4'h0;
                        state_d = ST_CNT;
                    end
                end
                ST_CNT:
                begin
                    if (tick)
                    begin
                        tick_d = tick_q + 4'h1;
                        if (tick_q == `OCD_SETTLE_TICKS - 4'h1)
                            state_d = ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    current_source_d  = new_source_select_q;
                    switch_request_d = 1'b0;
                    state_d = ST_IDLE;
                end
                default:
                    state_d = ST_IDLE;
            endcase
            // Lock tracks the PLL of whichever source is in play
            if (start_valid)
                lock_d = 1'b0;
            else if ((state_q != ST_IDLE && state_q != ST_CMP) && uses_pll(new_source_select_q))
                lock_d = pll_s;
            else if (uses_pll(current_source_q))
                lock_d = pll_s;
            // Failure set wins over any clear
            if (fail_s)
                cf_d = 1'b1;
            if (!sw_en)
            begin
                switch_request_d = 1'b0;
                state_d = ST_IDLE;
            end
        end
    end

    // Registers
    always_ff @(posedge CLK)
    begin
        cfg_sw_q  <= cfg_sw_d;
        cfg_src_q <= cfg_src_d;
        current_source_q    <= current_source_d;
        new_source_select_q    <= new_source_select_d;
        switch_request_q   <= switch_request_d;
        selection_lock_q <= selection_lock_d;
        lock_q    <= lock_d;
        cf_q      <= cf_d;
        drv_q     <= drv_d;
        secen_q   <= secen_d;
        state_q   <= state_d;
        tick_q    <= tick_d;
        nclk_q    <= RST ? 1'b0 : nclk_s;
    end

    // ----------------------------------------
    // Divider and trim registers
    // ----------------------------------------
    always_comb
    begin
        roi_d   = roi_q;
        doze_d  = doze_q;
        ratio_enable_d = ratio_enable_q;
        rc_postscaler_d = rc_postscaler_q;
        trim_d  = trim_q;
        if (RST)
        begin
            roi_d   = 1'b0;
            doze_d  = `OCD_DOZE_RST;
            ratio_enable_d = 1'b0;
            rc_postscaler_d = `OCD_RC_POSTSCALER_RST;
            trim_d  = `OCD_TRIM_RST;
        end
        else
        begin
            if (wr && hit_div && SEL_I[1])
            begin
                roi_d   = DAT_I[`OCD_B_ROI];
                doze_d  = DAT_I[`OCD_DOZE_LSB +: 3];
                ratio_enable_d = DAT_I[`OCD_B_RATIO_ENABLE];
                rc_postscaler_d = DAT_I[`OCD_RC_POSTSCALER_LSB +: 3];
            end
            if (wr && hit_trim && SEL_I[0])
                trim_d = DAT_I[5:0];
            // Interrupt wins over a same-cycle software set
            if (IRQ && roi_q)
                ratio_enable_d = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge CLK)
    begin
        roi_q   <= roi_d;
        doze_q  <= doze_d;
        ratio_enable_q <= ratio_enable_d;
        rc_postscaler_q <= rc_postscaler_d;
        trim_q  <= trim_d;
    end

    // ----------------------------------------
    // Bus answer and block outputs
    // ----------------------------------------
    always_comb
    begin
        ack_d = !RST && (wr || rd);
        dat_d = 32'h0000_0000;
        // Unmapped addresses still answer, reading zero
        if (rd && hit_osc)
            dat_d = {16'h0000, 1'b0, current_source_q, 1'b0, new_source_select_q, selection_lock_q, 1'b0,
                     lock_q, 1'b0, cf_q, drv_q, secen_q, switch_request_q};
        else if (rd && hit_div)
            dat_d = {16'h0000, roi_q, doze_q, ratio_enable_q, rc_postscaler_q, 8'h00};
        else if (rd && hit_trim)
            dat_d = {26'h0000000, trim_q};
        // Old source drops once current moves on; keepers stay up
        pwr_d = src_use(current_source_q);
        if (state_q != ST_IDLE)
            pwr_d = pwr_d | src_use(new_source_select_q);
        if (secen_q)
            pwr_d[4] = 1'b1;
        if (LOW_POWER_RC_USERS)
            pwr_d[1] = 1'b1;
        if (RST)
            pwr_d = 6'h00;
    end

    // Output registers
    always_ff @(posedge CLK)
    begin
        ACK_O          <= ack_d;
        DAT_O          <= dat_d;
        SYS_SOURCE     <= RST ? `OCD_SRC_FRC : current_source_q;
        {PRI_ON, SEC_ON, FRC_ON, SLOW_FRC_ON, LOW_POWER_RC_ON, PLL_ON} <= pwr_d;
        // Drive bit ignored for a digital secondary input
        SEC_HIGH_DRIVE <= !RST && CFG_SEC_CRYSTAL && (drv_q || CFG_SEC_HIGHPWR);
        DOZE_SHIFT     <= (RST || !ratio_enable_q) ? 3'h0 : doze_q;
        // Postscaler only meaningful on the two divided RC sources
        if (RST || (current_source_q != `OCD_SRC_FASTDIV && current_source_q != `OCD_SRC_SLOWDIV))
            RC_DIV_SHIFT <= 4'h0;
        else if (rc_postscaler_q == `OCD_RC_POSTSCALER_MAX)
            RC_DIV_SHIFT <= `OCD_RCSHIFT_MAX;
        else
            RC_DIV_SHIFT <= {1'b0, rc_postscaler_q};
        RC_TRIM        <= RST ? `OCD_TRIM_RST : trim_q;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_freeze;
        frozen |=> $stable(new_source_select_q) && $stable(selection_lock_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("selection changed while locked");

    property p_swdis;
        !sw_en |-> !switch_request_q && current_source_q == cfg_src_q;
    endproperty
    a_swdis: assert property (p_swdis) else $error("switch active while disabled");

    property p_fail;
        fail_s |=> cf_q;
    endproperty
    a_fail: assert property (p_fail) else $error("fail flag not set");

    property p_roi;
        IRQ && roi_q |=> !ratio_enable_q ##1 DOZE_SHIFT == 3'h0;
    endproperty
    a_roi: assert property (p_roi) else $error("interrupt did not end ratio");

    property p_abort;
        state_q == ST_CMP && new_source_select_q == current_source_q |=> !switch_request_q && state_q == ST_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("redundant switch not aborted");

    property p_startclr;
        start_valid && !fail_s |=> !lock_q && !cf_q;
    endproperty
    a_startclr: assert property (p_startclr) else $error("status not cleared");

    property p_settle;
        state_q == ST_CNT && tick && tick_q == `OCD_SETTLE_TICKS - 4'h1
            |=> state_q == ST_DONE;
    endproperty
    a_settle: assert property (p_settle) else $error("settle count wrong");

    property p_finish;
        state_q == ST_DONE |=> current_source_q == $past(new_source_select_q) && !switch_request_q ##1 SYS_SOURCE == current_source_q;
    endproperty
    a_finish: assert property (p_finish) else $error("changeover incomplete");

    property p_nopll;
        !uses_pll(current_source_q) && state_q == ST_IDLE |=> !lock_q;
    endproperty
    a_nopll: assert property (p_nopll) else $error("lock set without PLL");
endmodule

// ===== include/ocd_defines.svh
`ifndef OCD_DEFINES_SVH
`define OCD_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OCD_OFS_OSC      8'h00
`define OCD_OFS_DIV      8'h04
`define OCD_OFS_TRIM     8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OCD_B_SWREQ      0
`define OCD_B_SECEN      1
`define OCD_B_SECDRV     2
`define OCD_B_FAIL       3
`define OCD_B_SELECTION_LOCK    7
`define OCD_NEW_SOURCE_SELECT_LSB     8
`define OCD_RC_POSTSCALER_LSB    8
`define OCD_B_RATIO_ENABLE      11
`define OCD_DOZE_LSB     12
`define OCD_B_ROI        15

// ----------------------------------------
// Unlock keys, reset values, timing
// ----------------------------------------
`define OCD_KEY_HI1      8'h78
`define OCD_KEY_HI2      8'h9A
`define OCD_KEY_LO1      8'h46
`define OCD_KEY_LO2      8'h57
`define OCD_DOZE_RST     3'h3
`define OCD_RC_POSTSCALER_RST    3'h1
`define OCD_TRIM_RST     6'h00
`define OCD_SETTLE_TICKS 4'hA
`define OCD_RC_POSTSCALER_MAX    3'h7
`define OCD_RCSHIFT_MAX  4'h8

// ----------------------------------------
// Source selection codes
// ----------------------------------------
`define OCD_SRC_FRC      3'h0
`define OCD_SRC_FAST_RC_MULTIPLIED   3'h1
`define OCD_SRC_PRI      3'h2
`define OCD_SRC_PRIPLL   3'h3
`define OCD_SRC_SEC      3'h4
`define OCD_SRC_LOW_POWER_RC     3'h5
`define OCD_SRC_SLOWDIV  3'h6
`define OCD_SRC_FASTDIV  3'h7

`endif

// ===== include/ocd_pkg.sv
package ocd_pkg;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef logic [2:0] ocd_src_t;  // Oscillator source code

    // Clock-switch sequencer states
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_CMP,
        ST_WAIT,
        ST_CNT,
        ST_DONE
    } ocd_state_t;

endpackage

// ===== design/ocd_sync.sv
`timescale 1ns/1ps

// ----------------------------------------
// Two-flop synchroniser
// ----------------------------------------
module ocd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;  // First stage, read only by q
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    // Next values
    always_comb
    begin
        meta_d = rst ? '0 : d;
        q_d    = rst ? '0 : meta_q;
    end

    // Registers
    always_ff @(posedge clk)
    begin
        meta_q <= meta_d;
        q      <= q_d;
    end
endmodule

// ===== design/ocd_unlock.sv
`timescale 1ns/1ps

// ----------------------------------------
// Two-key unlock tracker for one byte
// ----------------------------------------
module ocd_unlock #(
    parameter logic [7:0] KEY1 = 8'h00,
    parameter logic [7:0] KEY2 = 8'h00
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       acc,
    input  wire logic       hit,
    input  wire logic [7:0] data,
    output logic            open
);
    logic [1:0] stage_q;  // 0 locked, 1 first key seen, 2 open
    logic [1:0] stage_d;

    // Any other write breaks the back-to-back chain
    always_comb
    begin
        stage_d = stage_q;
        if (rst)
            stage_d = 2'h0;
        else if (acc)
        begin
            if (hit && stage_q == 2'h2)
                stage_d = 2'h0;            // Write consumed, relock
            else if (hit && data == KEY1)
                stage_d = 2'h1;
            else if (hit && stage_q == 2'h1 && data == KEY2)
                stage_d = 2'h2;
            else
                stage_d = 2'h0;
        end
    end

    // Register
    always_ff @(posedge clk)
    begin
        stage_q <= stage_d;
    end

    assign open = (stage_q == 2'h2);
endmodule

// ===== test/ocd_top_tb.sv
`timescale 1ns/1ps
`include "ocd_defines.svh"
module ocd_top_tb;
    import ocd_pkg::*;
    // ----------------------------------------
    // Design ports, straps and counters
    // ----------------------------------------
    logic CLK = 0, RST = 1, CYC_I = 0, STB_I = 0, WE_I = 0, IRQ = 0;
    logic FAIL_DETECT = 0, NEW_CLK = 0, ACK_O, PRI_ON, SEC_ON, SEC_HIGH_DRIVE;
    logic FRC_ON, SLOW_FRC_ON, LOW_POWER_RC_ON, PLL_ON;
    logic [7:0]  ADR_I = 0;
    logic [3:0]  SEL_I = 0;
    logic [31:0] DAT_I = 0, DAT_O, rdat;
    logic [1:0]  CFG_SWITCHING = 2'h0;    // Switching and monitor on
    ocd_src_t    CFG_POWERON_SRC = 3'h7, SYS_SOURCE;
    logic CFG_PRI_CRYSTAL = 0, CFG_SEC_CRYSTAL = 1, CFG_SEC_HIGHPWR = 0;
    logic LOW_POWER_RC_USERS = 0, STARTUP_DONE = 1, PLL_LOCKED = 1;
    logic [2:0]  DOZE_SHIFT;
    logic [3:0]  RC_DIV_SHIFT;
    logic [5:0]  RC_TRIM;
    int miscompares = 0, n_tests = 0;
    // Rows: divider write value beside expected postscaler shift
    logic [19:0] rows [9] = '{20'h08000, 20'h19001, 20'h2A002, 20'h3B003,
        20'h4C004, 20'h5D005, 20'h6E006, 20'h7F008, 20'h77008};

    ocd_top dut (
        .CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
        .SEL_I(SEL_I), .DAT_I(DAT_I), .ACK_O(ACK_O), .DAT_O(DAT_O),
        .CFG_SWITCHING(CFG_SWITCHING), .CFG_POWERON_SRC(CFG_POWERON_SRC),
        .CFG_PRI_CRYSTAL(CFG_PRI_CRYSTAL), .CFG_SEC_CRYSTAL(CFG_SEC_CRYSTAL),
        .CFG_SEC_HIGHPWR(CFG_SEC_HIGHPWR), .LOW_POWER_RC_USERS(LOW_POWER_RC_USERS), .IRQ(IRQ),
        .FAIL_DETECT(FAIL_DETECT), .STARTUP_DONE(STARTUP_DONE), .PLL_LOCKED(PLL_LOCKED),
        .NEW_CLK(NEW_CLK), .SYS_SOURCE(SYS_SOURCE), .PRI_ON(PRI_ON), .SEC_ON(SEC_ON),
        .SEC_HIGH_DRIVE(SEC_HIGH_DRIVE), .FRC_ON(FRC_ON), .SLOW_FRC_ON(SLOW_FRC_ON),
        .LOW_POWER_RC_ON(LOW_POWER_RC_ON), .PLL_ON(PLL_ON), .DOZE_SHIFT(DOZE_SHIFT),
        .RC_DIV_SHIFT(RC_DIV_SHIFT), .RC_TRIM(RC_TRIM)
    );

    always #5 CLK = ~CLK;
    // New source clock, well under a quarter of CLK
    always #40 NEW_CLK = ~NEW_CLK;

    task automatic final_report;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [15:0] d);
        int k;
        k = 0;
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I  <= w;
        ADR_I <= a;
        SEL_I <= s;
        DAT_I <= {16'h0000, d};
        do
        begin
            @(posedge CLK);
            k++;
        end while (ACK_O !== 1'b1 && k < 20);
        rdat = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        if (k >= 20)
        begin
            miscompares++;
            final_report();
        end
        @(posedge CLK);
    endtask

    // Key pair then the protected byte write
    task automatic ulw(input logic hi, input logic [7:0] v);
        wb(1'b1, `OCD_OFS_OSC, hi ? 4'h2 : 4'h1, hi ? 16'h7878 : 16'h4646);
        wb(1'b1, `OCD_OFS_OSC, hi ? 4'h2 : 4'h1, hi ? 16'h9A9A : 16'h5757);
        wb(1'b1, `OCD_OFS_OSC, hi ? 4'h2 : 4'h1, {v, v});
    endtask

    // Full switch, then poll until the request bit drops
    task automatic sw(input ocd_src_t src);
        ulw(1'b1, {5'h00, src});
        ulw(1'b0, 8'h01);
        rdat = 32'h1;
        for (int k = 0; rdat[0] !== 1'b0; k++)
        begin
            if (k > 60)
                chk(rdat, 32'h0);
            if (k > 60)
                final_report();
            wb(1'b0, `OCD_OFS_OSC, 4'h3, 16'h0000);
        end
        repeat (2) @(posedge CLK);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        wb(1'b1, `OCD_OFS_OSC, 4'h2, 16'h0300);
        wb(1'b0, `OCD_OFS_OSC, 4'hF, 16'h0000);
        chk(rdat, 32'h7700);
        wb(1'b0, `OCD_OFS_DIV, 4'hF, 16'h0000);
        chk(rdat, 32'h3100);
        chk(RC_DIV_SHIFT, 4'h1);
        wb(1'b0, 8'h0C, 4'hF, 16'h0000);
        chk(rdat, 32'h0);
        $display("reset test done");
        // Ratio and postscaler table, last row with ratio disabled
        foreach (rows[i])
        begin
            wb(1'b1, `OCD_OFS_DIV, 4'h3, rows[i][19:4]);
            repeat (2) @(posedge CLK);
            chk(DOZE_SHIFT, rows[i][15] ? rows[i][18:16] : 3'h0);
            chk(RC_DIV_SHIFT, rows[i][3:0]);
        end
        $display("table test done");
        wb(1'b1, `OCD_OFS_TRIM, 4'h1, 16'h0020);
        chk(RC_TRIM, 6'h20);
        // Interrupt recovery from ratio 1:8
        wb(1'b1, `OCD_OFS_DIV, 4'h3, 16'hBB00);
        chk(DOZE_SHIFT, 3'h3);
        IRQ <= 1'b1;
        @(posedge CLK);
        IRQ <= 1'b0;
        repeat (3) @(posedge CLK);
        chk(DOZE_SHIFT, 3'h0);
        wb(1'b0, `OCD_OFS_DIV, 4'hF, 16'h0000);
        chk(rdat, 32'hB300);
        $display("irq test done");
        // Slow postscaled source, then plain fast RC, then redundant
        sw(3'h6);
        chk({SYS_SOURCE, SLOW_FRC_ON, RC_DIV_SHIFT}, 8'hD3);
        // Into the multiplied RC, never straight from a primary PLL mode
        sw(3'h1);
        wb(1'b0, `OCD_OFS_OSC, 4'h3, 16'h0000);
        chk(rdat, 32'h1120);
        chk({PLL_ON, FRC_ON, SYS_SOURCE}, 5'h19);
        sw(3'h0);
        chk({SYS_SOURCE, FRC_ON, SLOW_FRC_ON, PLL_ON, RC_DIV_SHIFT}, 10'h040);
        sw(3'h0);
        chk(rdat, 32'h0000);
        $display("switch test done");
        FAIL_DETECT <= 1'b1;
        repeat (5) @(posedge CLK);
        FAIL_DETECT <= 1'b0;
        wb(1'b0, `OCD_OFS_OSC, 4'h3, 16'h0000);
        chk(rdat, 32'h0008);
        ulw(1'b0, 8'h86);
        ulw(1'b1, 8'h05);
        wb(1'b0, `OCD_OFS_OSC, 4'h3, 16'h0000);
        chk(rdat, 32'h0086);
        chk({SEC_ON, SEC_HIGH_DRIVE}, 2'h3);
        $display("lock test done");
        // Mid-run reset with switching disabled and a digital secondary input
        CFG_SWITCHING   <= 2'h2;
        CFG_SEC_CRYSTAL <= 1'b0;
        LOW_POWER_RC_USERS      <= 1'b1;
        RST             <= 1'b1;
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        wb(1'b0, `OCD_OFS_DIV, 4'hF, 16'h0000);
        chk(rdat, 32'h3100);
        ulw(1'b1, 8'h02);
        ulw(1'b0, 8'h07);
        wb(1'b0, `OCD_OFS_OSC, 4'h3, 16'h0000);
        chk(rdat, 32'h7206);
        chk({SEC_ON, SEC_HIGH_DRIVE}, 2'h2);
        chk({PRI_ON, LOW_POWER_RC_ON, FRC_ON}, 3'h3);
        // Long enough for a switch to finish, were it allowed
        repeat (120) @(posedge CLK);
        chk(SYS_SOURCE, 3'h7);
        // Interrupt leaves the ratio alone while recovery is off
        wb(1'b1, `OCD_OFS_DIV, 4'h3, 16'h3900);
        IRQ <= 1'b1;
        repeat (3) @(posedge CLK);
        IRQ <= 1'b0;
        chk(DOZE_SHIFT, 3'h3);
        $display("restart test done");
        final_report();
    end
endmodule
